// ### hdl/lpd_top.sv
// four-channel led pwm driver top
//
// Contract
// RL1: a pin toggles only while its enable bit is one.
// RL2: each channel has its own 3-bit rate select.
// RL3: rates 000..011 give 0.25..2 hz; 100, 101 give 128, 256 hz.
// RL4: each channel has its own 4-bit duty select.
// RL5: active time is (code+1)/16 of the period; 1111 is always on.
// RL6: all channels are disabled after power-up.
// RL7: first channel resets to 256 hz and 50 percent duty.
// RL8: other channels reset to 0.25 hz and 6.25 percent duty.
// RL9: reserved rate codes 110, 111 behave as 256 hz.
// RL10: period starts active; new settings apply at the next boundary.
module lpd_top
    import lpd_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_led_wr,
    input wire logic [1:0] i_led_wr_sel,
    input wire logic i_led_wr_enable,
    input wire logic [lpd_pkg::LPD_RATE_W-1:0] i_led_rate_select,
    input wire logic [lpd_pkg::LPD_DUTY_W-1:0] i_led_duty_select,
    output logic [lpd_pkg::LPD_CHANNELS-1:0] o_led_enable,
    output logic o_led_pin_a,
    output logic o_led_pin_b,
    output logic o_led_pin_c,
    output logic o_led_pin_d
);
    import lpd_pkg::*;

    logic [3:0] en_q, en_d;
    logic [2:0] rate_q [4];
    logic [2:0] rate_d [4];
    logic [3:0] duty_q [4];
    logic [3:0] duty_d [4];
    logic [12:0] div_q, div_d;
    logic tick_q, tick_d;
    logic [3:0] pins;

    // shared 4096 hz timebase pulse for all channels
    always_comb
    begin
        tick_d = (div_q == 13'(LPD_TICK_DIV - 1));
        div_d = tick_d ? 13'h0000 : div_q + 13'h0001;
    end

    // settings write port, one channel per write
    always_comb
    begin
        en_d = en_q;
        for (int c = 0; c < LPD_CHANNELS; c++)
        begin
            rate_d[c] = rate_q[c];
            duty_d[c] = duty_q[c];
        end
        if (i_led_wr)
        begin
            en_d[i_led_wr_sel] = i_led_wr_enable; // RL1
            rate_d[i_led_wr_sel] = i_led_rate_select; // RL2
            duty_d[i_led_wr_sel] = i_led_duty_select; // RL4
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_q <= '0;
            tick_q <= 1'b0;
            en_q <= '0; // RL6
            rate_q[0] <= LPD_RST_RATE_A; // RL7
            duty_q[0] <= LPD_RST_DUTY_A; // RL7
            for (int c = 1; c < LPD_CHANNELS; c++)
            begin
                rate_q[c] <= LPD_RST_RATE_BCD; // RL8
                duty_q[c] <= LPD_RST_DUTY_BCD; // RL8
            end
        end
        else
        begin
            div_q <= div_d;
            tick_q <= tick_d;
            en_q <= en_d;
            for (int c = 0; c < LPD_CHANNELS; c++)
            begin
                rate_q[c] <= rate_d[c];
                duty_q[c] <= duty_d[c];
            end
        end
    end

    // channel instances; each output pin is its channel's flip-flop
    for (genvar g = 0; g < LPD_CHANNELS; g++)
    begin : g_ch
        lpd_channel u_ch (
            .i_core_clk(i_core_clk),
            .i_rst(i_rst),
            .i_tick(tick_q),
            .i_enable(en_q[g]),
            .i_rate(rate_q[g]),
            .i_duty(duty_q[g]),
            .o_pin(pins[g])
        );
    end

    assign o_led_enable = en_q;
    assign o_led_pin_a = pins[0];
    assign o_led_pin_b = pins[1];
    assign o_led_pin_c = pins[2];
    assign o_led_pin_d = pins[3];

    chk_tick_gap: assert property (@(posedge i_core_clk) disable iff (i_rst)
        tick_q |=> !tick_q) else $error("tick too frequent");
    chk_wr_enable: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_led_wr |=> en_q[$past(i_led_wr_sel)] == $past(i_led_wr_enable))
        else $error("enable write lost"); // RL1
    chk_wr_rate: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_led_wr |=> rate_q[$past(i_led_wr_sel)] == $past(i_led_rate_select))
        else $error("rate write lost"); // RL2
    chk_wr_duty: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_led_wr |=> duty_q[$past(i_led_wr_sel)] == $past(i_led_duty_select))
        else $error("duty write lost"); // RL4
    chk_off_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !i_led_wr && en_q == 4'h0 |=> en_q == 4'h0)
        else $error("channel enabled itself"); // RL6
endmodule : lpd_top

// ### hdl/lpd_pkg.sv
// package of constants for the four-channel led pwm driver
package lpd_pkg;
    localparam int LPD_CHANNELS = 4;
    localparam int LPD_RATE_W = 3;
    localparam int LPD_DUTY_W = 4;
    localparam int LPD_PHASE_W = 4;
    // core clock rate in hertz
    localparam longint LPD_CLK_HZ = 25000000;
    // fastest tick: 16 sixteenths per period at 256 hz
    localparam longint LPD_FAST_HZ = 256 * 16;
    localparam int LPD_TICK_DIV = int'(LPD_CLK_HZ / LPD_FAST_HZ);
    // rate codes
    localparam logic [2:0] LPD_RATE_0P25 = 3'h0;
    localparam logic [2:0] LPD_RATE_0P5 = 3'h1;
    localparam logic [2:0] LPD_RATE_1 = 3'h2;
    localparam logic [2:0] LPD_RATE_2 = 3'h3;
    localparam logic [2:0] LPD_RATE_128 = 3'h4;
    localparam logic [2:0] LPD_RATE_256 = 3'h5;
    // prescale limits relative to the 4096 hz tick (ticks per step minus one)
    localparam logic [9:0] LPD_PRE_0P25 = 10'h3FF;
    localparam logic [9:0] LPD_PRE_0P5 = 10'h1FF;
    localparam logic [9:0] LPD_PRE_1 = 10'h0FF;
    localparam logic [9:0] LPD_PRE_2 = 10'h07F;
    localparam logic [9:0] LPD_PRE_128 = 10'h001;
    localparam logic [9:0] LPD_PRE_256 = 10'h000;
    // reset settings
    localparam logic [2:0] LPD_RST_RATE_A = 3'h5;
    localparam logic [3:0] LPD_RST_DUTY_A = 4'h7;
    localparam logic [2:0] LPD_RST_RATE_BCD = 3'h0;
    localparam logic [3:0] LPD_RST_DUTY_BCD = 4'h0;
endpackage : lpd_pkg

// ### hdl/lpd_channel.sv
// one pwm channel: prescaler, sixteen-step phase and output stage
module lpd_channel
    import lpd_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_tick,
    input wire logic i_enable,
    input wire logic [LPD_RATE_W-1:0] i_rate,
    input wire logic [LPD_DUTY_W-1:0] i_duty,
    output logic o_pin
);
    logic [9:0] pre_q, pre_d, limit;
    logic [LPD_PHASE_W-1:0] ph_q, ph_d;
    logic [2:0] rate_q, rate_d;
    logic [3:0] duty_q, duty_d;
    logic pin_q, pin_d;
    logic started_q, started_d;
    logic step;

    // rate decode; reserved codes hold the 256 hz rate
    always_comb
    begin
        case (rate_q) // RL3 RL9
            LPD_RATE_0P25: limit = LPD_PRE_0P25;
            LPD_RATE_0P5: limit = LPD_PRE_0P5;
            LPD_RATE_1: limit = LPD_PRE_1;
            LPD_RATE_2: limit = LPD_PRE_2;
            LPD_RATE_128: limit = LPD_PRE_128;
            default: limit = LPD_PRE_256;
        endcase
    end

    // settings latch only at a period boundary or while stopped, so a period is never torn;
    // the first period waits for a tick so its first sixteenth is whole
    always_comb
    begin
        step = i_tick && (pre_q == limit);
        pre_d = pre_q;
        ph_d = ph_q;
        rate_d = rate_q;
        duty_d = duty_q;
        started_d = started_q;
        if (!i_enable || !started_q)
        begin
            pre_d = '0;
            ph_d = '0;
            rate_d = i_rate;
            duty_d = i_duty;
            started_d = i_enable && i_tick; // RL10
        end
        else if (i_tick)
        begin
            pre_d = step ? 10'h000 : pre_q + 10'h001;
            if (step)
            begin
                ph_d = ph_q + 4'h1;
                if (ph_q == 4'hF)
                begin
                    rate_d = i_rate; // RL10
                    duty_d = i_duty; // RL10
                end
            end
        end
        // active for duty+1 sixteenths at period start
        pin_d = i_enable && started_d && (ph_d <= duty_d); // RL1 RL5 RL10
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pre_q <= '0;
            ph_q <= '0;
            rate_q <= LPD_RST_RATE_BCD;
            duty_q <= LPD_RST_DUTY_BCD;
            pin_q <= 1'b0;
            started_q <= 1'b0;
        end
        else
        begin
            started_q <= started_d;
            pre_q <= pre_d;
            ph_q <= ph_d;
            rate_q <= rate_d;
            duty_q <= duty_d;
            pin_q <= pin_d;
        end
    end

    assign o_pin = pin_q;

    chk_off_low: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !i_enable |=> !o_pin) else $error("pin active while off"); // RL1
    chk_full_duty: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_enable && started_q && duty_q == 4'hF && $past(duty_q) == 4'hF
        |=> o_pin) else $error("full duty not high"); // RL5
    chk_rate_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_enable && started_q && !(step && ph_q == 4'hF) |=> $stable(rate_q))
        else $error("rate changed mid period"); // RL10
endmodule : lpd_channel

// ### sim/lpd_led_load.sv
// led load model: counts the cycles each pwm pin spends lit
module lpd_led_load (
    input wire logic i_core_clk,
    input wire logic i_clear,
    input wire logic [3:0] i_pins,
    output logic [3:0][15:0] o_high_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    // a lit-cycle count is phase independent, so start latency cannot skew it
    always_ff @(posedge i_core_clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (i_clear)
                o_high_cnt[i] <= 16'h0000;
            else if (i_pins[i] === 1'b1)
                o_high_cnt[i] <= o_high_cnt[i] + 16'h0001;
        end
    end
endmodule : lpd_led_load

// ### sim/lpd_top_tb_top.sv
// testbench for the four-channel led pwm driver
module lpd_top_tb_top;
    import lpd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_led_wr = 1'b0;
    logic [1:0] i_led_wr_sel = 2'h0;
    logic i_led_wr_enable = 1'b0;
    logic [2:0] i_led_rate_select = 3'h0;
    logic [3:0] i_led_duty_select = 4'h0;
    logic [3:0] o_led_enable;
    logic [3:0] pins;
    logic clear = 1'b1;
    logic [3:0][15:0] high_cnt;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    localparam logic [15:0] STEP = 16'(LPD_TICK_DIV);

    // 25 mhz core clock
    always #20 i_core_clk = ~i_core_clk;

    lpd_top i_lpd_top (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_led_wr(i_led_wr), .i_led_wr_sel(i_led_wr_sel),
        .i_led_wr_enable(i_led_wr_enable),
        .i_led_rate_select(i_led_rate_select),
        .i_led_duty_select(i_led_duty_select), .o_led_enable(o_led_enable),
        .o_led_pin_a(pins[0]), .o_led_pin_b(pins[1]),
        .o_led_pin_c(pins[2]), .o_led_pin_d(pins[3]));

    lpd_led_load i_lpd_led_load (.i_core_clk(i_core_clk), .i_clear(clear),
        .i_pins(pins), .o_high_cnt(high_cnt));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one write per call; strobe stays high so calls can run back to back
    task automatic wr_ch(input logic [1:0] sel, input logic en,
                         input logic [2:0] rate, input logic [3:0] duty);
        i_led_wr = 1'b1;
        i_led_wr_sel = sel;
        i_led_wr_enable = en;
        i_led_rate_select = rate;
        i_led_duty_select = duty;
        @(negedge i_core_clk);
    endtask : wr_ch

    task automatic print_verdict();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // hang guard: the sequence needs about 47000 cycles
    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fails++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (6) @(negedge i_core_clk);
        i_rst = 1'b0;
        check(16'(o_led_enable), 16'h0000);
        check(16'(pins), 16'h0000);
        clear = 1'b0;
        // 256 hz, 128 hz, reserved code, and a disabled full-duty channel
        wr_ch(2'h0, 1'b1, 3'h5, 4'h0);
        wr_ch(2'h1, 1'b1, 3'h4, 4'h0);
        wr_ch(2'h2, 1'b1, 3'h6, 4'h1);
        wr_ch(2'h3, 1'b0, 3'h5, 4'hF);
        i_led_wr = 1'b0;
        @(negedge i_core_clk);
        check(16'(o_led_enable), 16'h0007);
        // periods start at the first shared tick, one divider span in
        repeat (6400) @(negedge i_core_clk);
        check(16'(pins), 16'h0007);
        // window spans every first pulse but no second period
        repeat (14000) @(negedge i_core_clk);
        check(high_cnt[0], STEP);
        check(high_cnt[1], 16'(2 * STEP));
        check(high_cnt[2], 16'(2 * STEP));
        check(high_cnt[3], 16'h0000);
        // full duty must never drop inside the period
        wr_ch(2'h3, 1'b1, 3'h5, 4'hF);
        i_led_wr = 1'b0;
        repeat (6200) @(negedge i_core_clk);
        clear = 1'b1;
        repeat (4) @(negedge i_core_clk);
        clear = 1'b0;
        repeat (20000) @(negedge i_core_clk);
        check(high_cnt[3], 16'd20000);
        // disabling mid-pulse drops the pin at once
        wr_ch(2'h3, 1'b0, 3'h5, 4'hF);
        i_led_wr = 1'b0;
        @(negedge i_core_clk);
        check(16'(pins[3]), 16'h0000);
        check(16'(o_led_enable), 16'h0007);
        print_verdict();
    end
endmodule : lpd_top_tb_top
